//--- uocr_defines.svh
// Offsets, field positions, reset values and timing counts of the OTG config registers.
// Assumes byte addressing on an APB bus with one 32-bit word per register.
`ifndef UOCR_DEFINES_SVH
`define UOCR_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UOCR_SOF_OFS 8'h00
`define UOCR_CFG1_OFS 8'h04
`define UOCR_CFG2_OFS 8'h08
`define UOCR_OTG_OFS 8'h0C
`define UOCR_PWR_OFS 8'h10

// ----------------------------------------
// Config one fields
// ----------------------------------------
`define UOCR_EYE_BIT 7
`define UOCR_DMON_BIT 6
`define UOCR_IDLE_BIT 4
`define UOCR_PP_LSB 0

// ----------------------------------------
// Config two fields
// ----------------------------------------
`define UOCR_CSEL_BIT 5
`define UOCR_PULL_BIT 4
`define UOCR_SER_BIT 3
`define UOCR_BOOST_BIT 2
`define UOCR_CMP_BIT 1
`define UOCR_XCVR_BIT 0

// ----------------------------------------
// OTG event flags and the power-enable bit
// ----------------------------------------
`define UOCR_ID_BIT 7
`define UOCR_TMR_BIT 6
`define UOCR_LINE_BIT 5
`define UOCR_ACT_BIT 4
`define UOCR_SESV_BIT 3
`define UOCR_SESE_BIT 2
`define UOCR_AVV_BIT 0
`define UOCR_PWR_BIT 0

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define UOCR_CFG1_MASK 8'hD3
`define UOCR_CFG2_MASK 8'h3F
`define UOCR_OTG_MASK 8'hFD
`define UOCR_PWR_MASK 8'h01
`define UOCR_RESET_VAL 8'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define UOCR_MS_NS 1000000
`define UOCR_CLK_NS 25
`define UOCR_MS_CYCLES (`UOCR_MS_NS / `UOCR_CLK_NS)

`endif

//--- uocr_pkg.sv
// Types shared by the OTG config register block.
// Assumes nothing beyond a SystemVerilog compiler.
package uocr_pkg;

  // ----------------------------------------
  // VBUS comparator results
  // ----------------------------------------
  typedef struct packed {
    logic vbus_valid;
    logic session_valid;
    logic session_end;
  } uocr_vbus_type;

  // ----------------------------------------
  // Ping-pong buffer enables
  // ----------------------------------------
  typedef struct packed {
    logic ep0_out;
    logic ep0_in;
    logic ep_upper;
  } uocr_pp_type;

  // ----------------------------------------
  // Bus line state
  // ----------------------------------------
  typedef struct packed {
    logic se0;
    logic jst;
  } uocr_line_type;

endpackage

//--- uocr_ms_tick.sv
// One-cycle pulse every CYCLES clocks while enabled.
// Assumes a single clock and asynchronous active-low reset.
module uocr_ms_tick #(
  parameter int CYCLES = 40000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Control and result
  input wire logic enable_i,
  output logic tick_o
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  logic [CW-1:0] cnt_q;
  wire at_end = (cnt_q == LAST);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q <= '0;
    end else if (!enable_i || at_end) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  assign tick_o = enable_i && at_end;
endmodule

//--- uocr_line_mon.sv
// Pulses when the line state has held CYCLES clocks and differs from the last stable state.
// Assumes the line state is already synchronous to clk_i.
module uocr_line_mon #(
  parameter int CYCLES = 40000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Line and result
  input wire uocr_pkg::uocr_line_type line_i,
  output logic stable_change_o
);
  import uocr_pkg::*;
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  uocr_line_type prev_q;
  uocr_line_type stable_q;
  logic [CW-1:0] cnt_q;
  wire moved = (line_i != prev_q);
  wire held = (cnt_q == LAST);
  wire fire = held && !moved && (prev_q != stable_q);

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_q <= '0;
      stable_q <= '0;
      cnt_q <= '0;
    end else begin
      prev_q <= line_i;
      if (moved) begin
        cnt_q <= '0;
      end else if (!held) begin
        cnt_q <= cnt_q + CW'(1);
      end
      if (fire) begin
        stable_q <= prev_q;
      end
    end
  end

  assign stable_change_o = fire;
endmodule

//--- uocr_top.sv
// OTG configuration and event-status registers behind an APB slave.
// Assumes all pin inputs are synchronous to clk_i and APB runs on clk_i.
//
// Design decisions made here: the register addresses and the APB interface to the registers.
`include "uocr_defines.svh"

module uocr_top #(
  parameter int MS_CYCLES = `UOCR_MS_CYCLES,
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Bus and chip status
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic low_speed_i,
  input wire logic id_i,
  input wire logic cpu_idle_i,
  input wire logic line_drive_i,
  // VBUS sources
  input wire uocr_pkg::uocr_vbus_type onchip_vbus_i,
  input wire uocr_pkg::uocr_vbus_type ext_vbus_i,
  input wire logic comparator_status_one_i,
  input wire logic comparator_status_two_i,
  // Configuration outputs
  output logic [7:0] sof_threshold_value_o,
  output logic eye_test_enable_o,
  output logic drive_monitor_n_o,
  output logic module_run_o,
  output uocr_pkg::uocr_pp_type pingpong_o,
  output uocr_pkg::uocr_vbus_type vbus_status_o,
  output logic vbus_pullup_o,
  output logic serial_ctrl_en_o,
  output logic dedicated_ctrl_en_o,
  output logic boost_enable_o,
  output logic ext_boost_ctrl_en_o,
  output logic comparator_enable_o,
  output logic ext_status_in_en_o,
  output logic xcvr_enable_o,
  output logic ext_xcvr_en_o,
  // Line state
  output logic live_j_indication_o,
  output logic se0_o
);
  import uocr_pkg::*;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [7:0] sof_q;
  logic [7:0] cfg1_q;
  logic [7:0] cfg2_q;
  logic [7:0] otg_q;
  logic [7:0] pwr_q;
  logic [31:0] prdata_q;

  wire [7:0] addr = paddr_i[7:0];
  wire hit_sof = (addr == `UOCR_SOF_OFS);
  wire hit_cfg1 = (addr == `UOCR_CFG1_OFS);
  wire hit_cfg2 = (addr == `UOCR_CFG2_OFS);
  wire hit_otg = (addr == `UOCR_OTG_OFS);
  wire hit_pwr = (addr == `UOCR_PWR_OFS);
  wire hit_any = hit_sof | hit_cfg1 | hit_cfg2 | hit_otg | hit_pwr;
  wire setup = psel_i && !penable_i;
  wire access = psel_i && penable_i;
  wire wr = access && pwrite_i && hit_any;
  wire [7:0] wbyte = pwdata_i[7:0];
  wire [7:0] rbyte = hit_sof ? sof_q :
                     hit_cfg1 ? cfg1_q :
                     hit_cfg2 ? cfg2_q :
                     hit_otg ? otg_q :
                     hit_pwr ? pwr_q : 8'h00;
  wire [31:0] prdata_d = (setup && !pwrite_i) ? {24'h00_0000, rbyte} : prdata_q;

  assign pready_o = 1'b1;
  assign pslverr_o = access && !hit_any;
  assign prdata_o = prdata_q;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sof_q <= `UOCR_RESET_VAL;
      cfg1_q <= `UOCR_RESET_VAL;
      cfg2_q <= `UOCR_RESET_VAL;
      pwr_q <= `UOCR_RESET_VAL;
      prdata_q <= '0;
    end else begin
      prdata_q <= prdata_d;
      if (wr && hit_sof) sof_q <= wbyte;
      if (wr && hit_cfg1) cfg1_q <= wbyte & `UOCR_CFG1_MASK;
      if (wr && hit_cfg2) cfg2_q <= wbyte & `UOCR_CFG2_MASK;
      if (wr && hit_pwr) pwr_q <= wbyte & `UOCR_PWR_MASK;
    end
  end

  // ----------------------------------------
  // Configuration decode
  // ----------------------------------------
  wire [1:0] pp_mode = cfg1_q[`UOCR_PP_LSB +: 2];
  wire xcvr_dis = cfg2_q[`UOCR_XCVR_BIT];
  wire cmp_dis = cfg2_q[`UOCR_CMP_BIT];
  wire boost_dis = cfg2_q[`UOCR_BOOST_BIT];
  wire pwr_en = pwr_q[`UOCR_PWR_BIT];

  assign sof_threshold_value_o = sof_q;
  assign eye_test_enable_o = cfg1_q[`UOCR_EYE_BIT];
  assign drive_monitor_n_o = !(cfg1_q[`UOCR_DMON_BIT] && xcvr_dis && line_drive_i);
  assign module_run_o = pwr_en && !(cfg1_q[`UOCR_IDLE_BIT] && cpu_idle_i);
  assign pingpong_o.ep0_out = (pp_mode == 2'b10) || (pp_mode == 2'b01);
  assign pingpong_o.ep0_in = (pp_mode == 2'b10);
  assign pingpong_o.ep_upper = pp_mode[1];
  assign vbus_pullup_o = cfg2_q[`UOCR_PULL_BIT];
  assign serial_ctrl_en_o = cfg2_q[`UOCR_SER_BIT];
  assign dedicated_ctrl_en_o = !cfg2_q[`UOCR_SER_BIT];
  assign boost_enable_o = !boost_dis;
  assign ext_boost_ctrl_en_o = boost_dis;
  assign comparator_enable_o = !cmp_dis;
  assign ext_status_in_en_o = cmp_dis;
  assign xcvr_enable_o = !xcvr_dis;
  assign ext_xcvr_en_o = xcvr_dis;

  // ----------------------------------------
  // VBUS source selection
  // ----------------------------------------
  uocr_vbus_type enc_vbus;
  uocr_vbus_type dig_vbus;
  uocr_vbus_type vbus_sel;
  assign enc_vbus.vbus_valid = comparator_status_two_i && comparator_status_one_i;
  assign enc_vbus.session_valid = comparator_status_two_i || comparator_status_one_i;
  assign enc_vbus.session_end = !comparator_status_two_i && !comparator_status_one_i;
  assign dig_vbus = cfg2_q[`UOCR_CSEL_BIT] ? ext_vbus_i : enc_vbus;
  assign vbus_sel = cmp_dis ? dig_vbus : onchip_vbus_i;

  // ----------------------------------------
  // Line state and event sources
  // ----------------------------------------
  uocr_vbus_type vbus_q;
  uocr_line_type line_now;
  uocr_line_type line_q;
  logic id_q;
  logic [1:0] dpdm_q;
  logic ms_tick;
  logic line_evt;
  // Low until the history flops hold real pin levels
  logic primed_q;

  assign line_now.se0 = !dp_i && !dm_i;
  assign line_now.jst = low_speed_i ? (!dp_i && dm_i) : (dp_i && !dm_i);
  assign vbus_status_o = vbus_q;
  assign live_j_indication_o = line_q.jst;
  assign se0_o = line_q.se0;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      vbus_q <= '0;
      line_q <= '0;
      id_q <= 1'b0;
      dpdm_q <= 2'b00;
      primed_q <= 1'b0;
    end else begin
      primed_q <= 1'b1;
      vbus_q <= vbus_sel;
      line_q <= line_now;
      id_q <= id_i;
      dpdm_q <= {dp_i, dm_i};
    end
  end

  uocr_ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_ms_tick (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .enable_i(module_run_o),
    .tick_o(ms_tick)
  );

  uocr_line_mon #(
    .CYCLES(MS_CYCLES)
  ) u_line_mon (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .line_i(line_q),
    .stable_change_o(line_evt)
  );

  // ----------------------------------------
  // OTG event flags
  // ----------------------------------------
  // No false edge from reset values on the first edge after release
  wire vv_chg = primed_q && (vbus_sel.vbus_valid != vbus_q.vbus_valid);
  wire sv_chg = primed_q && (vbus_sel.session_valid != vbus_q.session_valid);
  wire se_chg = primed_q && (vbus_sel.session_end != vbus_q.session_end);
  wire act_chg = primed_q && (({dp_i, dm_i} != dpdm_q) || vv_chg);
  logic [7:0] evt;
  always_comb begin
    evt = 8'h00;
    evt[`UOCR_ID_BIT] = primed_q && (id_i != id_q);
    evt[`UOCR_TMR_BIT] = ms_tick;
    evt[`UOCR_LINE_BIT] = line_evt;
    evt[`UOCR_ACT_BIT] = act_chg;
    evt[`UOCR_SESV_BIT] = sv_chg;
    evt[`UOCR_SESE_BIT] = se_chg;
    evt[`UOCR_AVV_BIT] = vv_chg;
  end

  wire [7:0] clr = (wr && hit_otg) ? wbyte : 8'h00;
  wire [7:0] otg_d = ((otg_q & ~clr) | evt) & `UOCR_OTG_MASK;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      otg_q <= `UOCR_RESET_VAL;
    end else begin
      otg_q <= otg_d;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  wire wr_otg = wr && hit_otg;

  sof_write_a: assert property (wr && hit_sof |=> sof_threshold_value_o == $past(pwdata_i[7:0]))
    else $error("sof threshold not stored");
  upper_zero_a: assert property (access |-> prdata_o[31:8] == 24'h00_0000)
    else $error("upper read bits not zero");
  eye_write_a: assert property (wr && hit_cfg1 |=> eye_test_enable_o == $past(pwdata_i[7]))
    else $error("eye test bit not stored");
  drive_mark_a: assert property (!drive_monitor_n_o |-> ext_xcvr_en_o && line_drive_i)
    else $error("drive marker active without cause");
  idle_halt_a: assert property (cpu_idle_i && cfg1_q[4] |-> !module_run_o)
    else $error("module runs in idle with halt set");
  pp_upper_a: assert property (wr && hit_cfg1 && pwdata_i[1:0] == 2'b11 |=> pingpong_o == 3'b001)
    else $error("ping-pong decode wrong for mode three");
  id_flag_a: assert property ($changed(id_i) && $past(reset_n_i) |=> otg_q[7])
    else $error("id change not flagged");
  tick_flag_a: assert property (ms_tick |=> otg_q[6])
    else $error("timer expiry not flagged");
  bit1_zero_a: assert property (otg_q[1] == 1'b0)
    else $error("reserved status bit set");
  vbus_cross_a: assert property ($changed(vbus_sel.vbus_valid) && $past(reset_n_i) |=> otg_q[0])
    else $error("vbus valid crossing not flagged");
  clear_all_a: assert property (wr_otg && pwdata_i[7:0] == 8'hFF && evt == 8'h00 |=> otg_q == 8'h00)
    else $error("full word clear left flags");
  set_wins_a: assert property (wr_otg && pwdata_i[7] && evt[7] |=> otg_q[7])
    else $error("event lost to clear");
  keep_flag_a: assert property (otg_q[5] && !(wr_otg && pwdata_i[5]) |=> otg_q[5])
    else $error("line flag lost without clear");

  // ----------------------------------------
  // Selection and enable checks
  // ----------------------------------------
  pp_all_a: assert property (wr && hit_cfg1 && pwdata_i[1:0] == 2'b10 |=> pingpong_o == 3'b111)
    else $error("ping-pong decode wrong for mode two");
  pp_off_a: assert property (wr && hit_cfg1 && pwdata_i[1:0] == 2'b00 |=> pingpong_o == 3'b000)
    else $error("ping-pong decode wrong for mode zero");
  idle_run_a: assert property (pwr_en && !cpu_idle_i |-> module_run_o)
    else $error("module halted outside idle");
  power_gate_a: assert property (!pwr_en |-> !module_run_o)
    else $error("module runs without power enable");
  upper_cfg2_a: assert property (wr && hit_cfg2 |=> cfg2_q[7:6] == 2'b00)
    else $error("unimplemented config bits stored");
  three_pin_a: assert property (cmp_dis && cfg2_q[5] |=> vbus_status_o == $past(ext_vbus_i))
    else $error("three-pin status not selected");
  enc_valid_a: assert property (cmp_dis && !cfg2_q[5] && comparator_status_one_i
    && comparator_status_two_i |=> vbus_status_o.vbus_valid)
    else $error("encoded VBUS valid not decoded");
  onchip_pick_a: assert property (comparator_enable_o |=> vbus_status_o == $past(onchip_vbus_i))
    else $error("on-chip comparator not selected");
  pullup_wr_a: assert property (wr && hit_cfg2 |=> vbus_pullup_o == $past(pwdata_i[4]))
    else $error("VBUS pull-up enable not stored");
  serial_wr_a: assert property (wr && hit_cfg2 |=>
    serial_ctrl_en_o == $past(pwdata_i[3]) && dedicated_ctrl_en_o == !$past(pwdata_i[3]))
    else $error("external control select not stored");
  boost_wr_a: assert property (wr && hit_cfg2 |=>
    ext_boost_ctrl_en_o == $past(pwdata_i[2]) && boost_enable_o == !$past(pwdata_i[2]))
    else $error("boost regulator select not stored");
  cmp_wr_a: assert property (wr && hit_cfg2 |=>
    ext_status_in_en_o == $past(pwdata_i[1]) && comparator_enable_o == !$past(pwdata_i[1]))
    else $error("comparator select not stored");
  xcvr_wr_a: assert property (wr && hit_cfg2 |=>
    ext_xcvr_en_o == $past(pwdata_i[0]) && xcvr_enable_o == !$past(pwdata_i[0]))
    else $error("transceiver select not stored");

  // ----------------------------------------
  // Event source checks
  // ----------------------------------------
  quiet_start_a: assert property (!$past(reset_n_i) |=> otg_q == 8'h00)
    else $error("event flagged right after reset");
  line_flag_a: assert property (line_evt |=> otg_q[5])
    else $error("stable line change not flagged");
  act_flag_a: assert property ($changed(dp_i) && $past(reset_n_i) |=> otg_q[4])
    else $error("line activity not flagged");
  sess_flag_a: assert property ($changed(vbus_sel.session_valid) && $past(reset_n_i) |=> otg_q[3])
    else $error("session valid crossing not flagged");
  send_flag_a: assert property ($changed(vbus_sel.session_end) && $past(reset_n_i) |=> otg_q[2])
    else $error("session end crossing not flagged");
  live_j_indication_a: assert property (!low_speed_i && dp_i && !dm_i |=> live_j_indication_o)
    else $error("full speed J not indicated");

  tick_seen_c: cover property (ms_tick ##1 otg_q[6]);
  line_seen_c: cover property (line_evt ##1 otg_q[5]);
  clear_seen_c: cover property (otg_q != 8'h00 ##1 wr_otg ##1 otg_q == 8'h00);
  id_seen_c: cover property ($changed(id_i) ##1 otg_q[7]);
  vbus_seen_c: cover property (vv_chg ##1 otg_q[0]);
endmodule

//--- uocr_far_model.sv
// Behavioural external transceiver and VBUS comparator facing the config block.
// Assumes its controls change just after a rising clock edge.
module uocr_far_model (
  // Controls from the bench
  input wire logic j_line_i,
  input wire logic id_lvl_i,
  input wire logic [1:0] stage_i,
  input wire logic three_pin_i,
  // Pins toward the block
  output logic dp_o,
  output logic dm_o,
  output logic id_o,
  output uocr_pkg::uocr_vbus_type vbus3_o,
  output logic status_one_o,
  output logic status_two_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import uocr_pkg::*;
  uocr_vbus_type lvl;
  logic [1:0] enc;
  // Full-speed J when asked, K otherwise
  assign dp_o = j_line_i;
  assign dm_o = ~j_line_i;
  assign id_o = id_lvl_i;
  // Stage 0 below session end, 1 session valid, 2 VBUS valid
  assign lvl = (stage_i == 2'h0) ? 3'h1 : (stage_i == 2'h1) ? 3'h2 : 3'h6;
  assign enc = (stage_i == 2'h0) ? 2'h0 : (stage_i == 2'h1) ? 2'h1 : 2'h3;
  // Unused interface shows the inverse, never a stale copy
  assign vbus3_o = three_pin_i ? lvl : ~lvl;
  assign {status_two_o, status_one_o} = three_pin_i ? ~enc : enc;
endmodule

//--- usb_otg_config_irq_regs_bench.sv
// Self-checking bench for the OTG config and event register block.
// Assumes the far-side model and the design files are compiled first.
`include "uocr_defines.svh"
module usb_otg_config_irq_regs_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import uocr_pkg::*;
  localparam int MS = 8;
  logic clk_i, reset_n_i, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0] paddr, sof;
  logic [31:0] pwdata, prdata, rd, x;
  logic dp, dm, low_speed, id, cpu_idle, line_drive, so1, so2, j_cmd, id_cmd, three_pin;
  logic [1:0] stage;
  uocr_vbus_type onchip, ext, vstat;
  uocr_pp_type pp;
  logic eye, dmon_n, run, pull, ser, ded, boost, xboost, cmpen, xstat, xcvr, xxcvr, livej, se0;
  logic [31:0] ppx [4] = '{32'h0, 32'h4, 32'h7, 32'h1};
  logic [31:0] v3x [3] = '{32'h1, 32'h2, 32'h6};
  int n_fail, cmp_count;

  uocr_top #(.MS_CYCLES(MS)) dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .dp_i(dp), .dm_i(dm), .low_speed_i(low_speed), .id_i(id), .cpu_idle_i(cpu_idle),
    .line_drive_i(line_drive), .onchip_vbus_i(onchip), .ext_vbus_i(ext), .comparator_status_one_i(so1),
    .comparator_status_two_i(so2), .sof_threshold_value_o(sof), .eye_test_enable_o(eye),
    .drive_monitor_n_o(dmon_n), .module_run_o(run), .pingpong_o(pp), .vbus_status_o(vstat),
    .vbus_pullup_o(pull), .serial_ctrl_en_o(ser), .dedicated_ctrl_en_o(ded), .boost_enable_o(boost),
    .ext_boost_ctrl_en_o(xboost), .comparator_enable_o(cmpen), .ext_status_in_en_o(xstat),
    .xcvr_enable_o(xcvr), .ext_xcvr_en_o(xxcvr), .live_j_indication_o(livej), .se0_o(se0));
  uocr_far_model far (.j_line_i(j_cmd), .id_lvl_i(id_cmd), .stage_i(stage), .three_pin_i(three_pin),
    .dp_o(dp), .dm_o(dm), .id_o(id), .vbus3_o(ext), .status_one_o(so1), .status_two_o(so2));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic check_pin(input logic got, input logic exp, input string what);
    check_reg({31'h0, got}, {31'h0, exp}, what);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One APB transfer; tog flips the ID pin as the access phase starts
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic tog = 1'b0);
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    if (tog) id_cmd <= ~id_cmd;
    do begin
      @(posedge clk_i);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic stop_test();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog, tests
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    #(25 * 5000);
    n_fail++;
    stop_test();
  end
  initial begin
    {reset_n_i, psel, penable, pwrite, low_speed, id_cmd, cpu_idle, line_drive, j_cmd} = 9'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    onchip = 3'h0;
    stage = 2'h0;
    three_pin = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    cyc(6);
    reset_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      check_reg(rd, 32'h0, "reset value");
    end
    check_reg({28'h0, xcvr, boost, dmon_n, run}, 32'he, "reset pins");
    apb(1'b1, `UOCR_SOF_OFS, 32'hffff_ff4a);
    apb(1'b0, `UOCR_SOF_OFS, 32'h0);
    check_reg(rd, 32'h4a, "sof threshold");
    check_reg({24'h0, sof}, 32'h4a, "sof pins");
    apb(1'b1, `UOCR_CFG1_OFS, 32'hffff_ffff);
    apb(1'b0, `UOCR_CFG1_OFS, 32'h0);
    check_reg(rd, 32'hd3, "cfg1 mask");
    check_pin(eye, 1'b1, "eye test");
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, `UOCR_CFG1_OFS, 32'(m));
      cyc(2);
      check_reg({29'h0, pp}, ppx[m], "pingpong");
    end
    check_pin(eye, 1'b0, "eye off");
    $display("test config one done");
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, `UOCR_CFG2_OFS, 32'(1 << i));
      apb(1'b0, `UOCR_CFG2_OFS, 32'h0);
      check_reg(rd, 32'(1 << i), "cfg2 readback");
      x = {23'h0, rd[4], rd[3], ~rd[3], ~rd[2], rd[2], ~rd[1], rd[1], ~rd[0], rd[0]};
      check_reg({23'h0, pull, ser, ded, boost, xboost, cmpen, xstat, xcvr, xxcvr}, x, "cfg2 pins");
    end
    apb(1'b1, `UOCR_CFG1_OFS, 32'h40);
    line_drive <= 1'b1;
    cyc(2);
    check_pin(dmon_n, 1'b1, "monitor with on-chip xcvr");
    apb(1'b1, `UOCR_CFG2_OFS, 32'h1);
    cyc(2);
    check_pin(dmon_n, 1'b0, "monitor driving");
    line_drive <= 1'b0;
    cyc(2);
    check_pin(dmon_n, 1'b1, "monitor idle");
    $display("test config two done");
    apb(1'b1, `UOCR_PWR_OFS, 32'h1);
    apb(1'b1, `UOCR_CFG1_OFS, 32'h10);
    cpu_idle <= 1'b1;
    cyc(2);
    check_pin(run, 1'b0, "halt in idle");
    apb(1'b1, `UOCR_CFG1_OFS, 32'h0);
    cyc(2);
    check_pin(run, 1'b1, "run in idle");
    cpu_idle <= 1'b0;
    apb(1'b1, `UOCR_OTG_OFS, 32'hff);
    cyc(MS + 2);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd & 32'h40, 32'h40, "ms timer");
    apb(1'b1, `UOCR_PWR_OFS, 32'h0);
    apb(1'b1, `UOCR_OTG_OFS, 32'hff);
    cyc(MS + 4);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h0, "timer stopped");
    $display("test power done");
    apb(1'b1, `UOCR_CFG2_OFS, 32'h22);
    for (int s = 0; s < 3; s++) begin
      stage <= 2'(s);
      cyc(3);
      check_reg({29'h0, vstat}, v3x[s], "three-pin status");
    end
    three_pin <= 1'b0;
    apb(1'b1, `UOCR_CFG2_OFS, 32'h2);
    for (int s = 0; s < 3; s++) begin
      stage <= 2'(s);
      cyc(3);
      check_reg({29'h0, vstat} & 32'h5, v3x[s] & 32'h5, "encoded status");
    end
    apb(1'b1, `UOCR_CFG2_OFS, 32'h0);
    onchip <= 3'h6;
    cyc(3);
    check_reg({29'h0, vstat}, 32'h6, "on-chip status");
    onchip <= 3'h0;
    three_pin <= 1'b1;
    stage <= 2'h0;
    apb(1'b1, `UOCR_CFG2_OFS, 32'h22);
    $display("test comparator done");
    apb(1'b1, `UOCR_OTG_OFS, 32'hff);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h0, "events cleared");
    id_cmd <= ~id_cmd;
    cyc(2);
    stage <= 2'h1;
    cyc(2);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h8c, "id and session");
    apb(1'b1, `UOCR_OTG_OFS, 32'h84);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h08, "selective clear");
    stage <= 2'h2;
    cyc(2);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h19, "vbus valid rise");
    apb(1'b1, `UOCR_OTG_OFS, 32'hff);
    stage <= 2'h0;
    cyc(2);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h1d, "falling crossings");
    apb(1'b1, `UOCR_OTG_OFS, 32'hff);
    j_cmd <= 1'b1;
    cyc(MS + 4);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd, 32'h30, "line stable");
    check_reg({30'h0, livej, se0}, 32'h2, "full speed J");
    low_speed <= 1'b1;
    cyc(2);
    check_pin(livej, 1'b0, "low speed J");
    low_speed <= 1'b0;
    apb(1'b1, `UOCR_OTG_OFS, 32'hff);
    id_cmd <= ~id_cmd;
    cyc(2);
    apb(1'b1, `UOCR_OTG_OFS, 32'h80, 1'b1);
    apb(1'b0, `UOCR_OTG_OFS, 32'h0);
    check_reg(rd & 32'h80, 32'h80, "set wins over clear");
    $display("test events done");
    apb(1'b1, 8'h14, 32'hff);
    check_pin(err, 1'b1, "unmapped write error");
    apb(1'b0, 8'h14, 32'h0);
    check_reg(rd, 32'h0, "unmapped read");
    apb(1'b0, `UOCR_SOF_OFS, 32'h0);
    check_pin(err, 1'b0, "mapped no error");
    $display("test unmapped done");
    stop_test();
  end
endmodule
